/* design/pcs_pkg.sv */
package pcs_pkg;

   localparam int PCS_PC_W       = 13;
   localparam int PCS_LOW_W      = 8;
   localparam int PCS_HIGH_W     = 5;
   localparam int PCS_TARGET_W   = 11;
   localparam int PCS_STACK_D    = 8;
   localparam int PCS_SP_W       = 3;

   // Printed offsets are register indices; byte address is four times the index
   localparam logic [11:0] PCS_IDX_PC_LOW    = 12'h182;
   localparam logic [11:0] PCS_IDX_PC_HIGH   = 12'h18A;
   localparam logic [13:0] PCS_ADDR_PC_LOW   = {PCS_IDX_PC_LOW, 2'b00};
   localparam logic [13:0] PCS_ADDR_PC_HIGH  = {PCS_IDX_PC_HIGH, 2'b00};
   localparam int          PCS_ADDR_W        = 14;

   localparam logic [7:0]  PCS_PC_LOW_RST    = 8'h00;
   localparam logic [4:0]  PCS_PC_HIGH_RST   = 5'h00;
   localparam logic [12:0] PCS_PC_RST        = 13'h0000;
   localparam int          PCS_PAGE_LSB      = 3;
   localparam logic [12:0] PCS_VECTOR_DEF    = 13'h0008;

   localparam logic [1:0]  PCS_HTRANS_IDLE   = 2'b00;
   localparam logic [1:0]  PCS_HTRANS_NONSEQ = 2'b10;

   typedef enum logic [1:0] {
      PCS_SEL_NONE = 2'b00,
      PCS_SEL_LOW  = 2'b01,
      PCS_SEL_HIGH = 2'b10
   } pcs_sel_t;

   // One cycle of sequencing request from the instruction decoder
   typedef struct packed {
      logic                      inc;
      logic                      call;
      logic                      jump;
      logic                      ret;
      logic                      irq;
      logic [PCS_TARGET_W-1:0]   target;
   } pcs_op_t;

endpackage

/* design/pcs_stack.sv */
`timescale 1ns/100ps
module pcs_stack
   import pcs_pkg::*;
#(
   parameter int DEPTH = PCS_STACK_D,
   parameter int WIDTH = PCS_PC_W
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             push,
   input  wire logic             pop,
   input  wire logic [WIDTH-1:0] push_data,
   output logic      [WIDTH-1:0] top
);

   localparam int SPW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [SPW-1:0]   sp_r;
   logic [SPW-1:0]   sp_dec;

   assign sp_dec = sp_r - 1'b1;
   assign top    = mem_r[sp_dec];

   // Pointer never leaves the block and simply wraps, no overflow flag [RULE10] [RULE14] [RULE15]
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sp_r <= '0;
      end else if (push) begin
         sp_r <= sp_r + 1'b1;
      end else if (pop) begin
         sp_r <= sp_dec;
      end
   end

   // Ninth push lands on the slot of the first [RULE9] [RULE14]
   always_ff @(posedge clk) begin
      if (push) begin
         mem_r[sp_r] <= push_data;
      end
   end

   property p_sp_wrap;
      @(posedge clk) disable iff (!rst_n)
      (push && sp_r == SPW'(DEPTH-1)) |=> (sp_r == '0);
   endproperty
   a_sp_wrap: assert property (p_sp_wrap) else $error("stack pointer did not wrap"); // [RULE14]

   property p_push_pop_top;
      @(posedge clk) disable iff (!rst_n)
      (push && !pop) |=> (top == $past(push_data));
   endproperty
   a_push_pop_top: assert property (p_push_pop_top) else $error("pushed word not on top"); // [RULE11]

   c_wrap: cover property (@(posedge clk) disable iff (!rst_n) push && sp_r == SPW'(DEPTH-1));

endmodule // pcs_stack

/* design/pcs_core.sv */
// Design decision made here: the AHB-Lite interface to the registers.
`timescale 1ns/100ps
// Contract
// RULE1 - The program counter is thirteen bits wide and addresses instruction words.
// RULE2 - The counter's low byte is the pc_low_byte_reg register, readable and writable by software.
// RULE3 - The upper five counter bits are not software visible and are loaded from pc_high_latch.
// RULE4 - Any reset clears the whole program counter.
// RULE5 - A write to pc_low_byte_reg loads the counter with pc_high_latch bits four to zero above the written byte.
// RULE6 - A call or goto takes counter bits twelve and eleven from pc_high_latch bits four and three.
// RULE7 - A call or goto takes the lower eleven counter bits from the instruction operand.
// RULE8 - Software doing computed jumps must keep tables inside one 256-word block, as the high part never carries.
// RULE9 - A return stack of eight thirteen-bit entries sits outside program and data space.
// RULE10 - The stack pointer is internal and cannot be read or written by software.
// RULE11 - A call or an interrupt vector branch pushes the program counter onto the stack.
// RULE12 - A return, return_with_literal or return_from_interrupt pops the stack into the counter.
// RULE13 - Pushes and pops leave pc_high_latch unchanged.
// RULE14 - The stack wraps circularly, each push past eight overwriting the oldest entry in order.
// RULE15 - No status shows stack overflow or underflow.
// RULE16 - pc_high_latch implements only five bits reset to zero, its top three bits reading zero.
module pcs_core
   import pcs_pkg::*;
#(
   parameter logic [PCS_PC_W-1:0] VECTOR = PCS_VECTOR_DEF,
   parameter int                  DEPTH  = PCS_STACK_D
) (
   input  wire logic                  clk,
   input  wire logic                  rst_n,
   input  wire logic                  hsel,
   input  wire logic [31:0]           haddr,
   input  wire logic [1:0]            htrans,
   input  wire logic                  hwrite,
   input  wire logic [2:0]            hsize,
   input  wire logic                  hready,
   input  wire logic [31:0]           hwdata,
   output logic      [31:0]           hrdata,
   output logic                       hreadyout,
   output logic                       hresp,
   input  wire pcs_op_t               op,
   output logic      [PCS_PC_W-1:0]   pc
);

   logic [PCS_PC_W-1:0]   pc_r;
   logic [PCS_HIGH_W-1:0] pc_high_latch_r;
   pcs_sel_t              wr_sel_r;
   logic [31:0]           hrdata_r;
   logic                  addr_ok;
   pcs_sel_t              addr_sel;
   logic                  wr_low;
   logic                  wr_high;
   logic                  push;
   logic                  pop;
   logic [PCS_PC_W-1:0]   push_data;
   logic [PCS_PC_W-1:0]   stack_top;
   logic [PCS_PC_W-1:0]   pc_nxt;
   logic [PCS_HIGH_W-1:0] latch_fwd;
   logic [7:0]            low_fwd;

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;
   assign hrdata    = hrdata_r;
   assign pc        = pc_r;

   // Address phase decode; only whole-word transfers hit a register
   assign addr_ok = hsel && hready && htrans[1] && (hsize == 3'b010);

   always_comb begin
      addr_sel = PCS_SEL_NONE;
      if (addr_ok && haddr[PCS_ADDR_W-1:0] == PCS_ADDR_PC_LOW && haddr[31:PCS_ADDR_W] == '0) begin
         addr_sel = PCS_SEL_LOW;
      end else if (addr_ok && haddr[PCS_ADDR_W-1:0] == PCS_ADDR_PC_HIGH && haddr[31:PCS_ADDR_W] == '0) begin
         addr_sel = PCS_SEL_HIGH;
      end
   end

   // Write data phase follows the captured address phase
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_sel_r <= PCS_SEL_NONE;
      end else if (hready) begin
         wr_sel_r <= hwrite ? addr_sel : PCS_SEL_NONE;
      end
   end

   assign wr_low  = (wr_sel_r == PCS_SEL_LOW);
   assign wr_high = (wr_sel_r == PCS_SEL_HIGH);

   // Only five bits exist; the stack never touches them [RULE16] [RULE13] [RULE3]
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pc_high_latch_r <= PCS_PC_HIGH_RST;
      end else if (wr_high) begin
         pc_high_latch_r <= hwdata[PCS_HIGH_W-1:0];
      end
   end

   // Forward a write in flight so a back-to-back read sees it
   assign latch_fwd = wr_high ? hwdata[PCS_HIGH_W-1:0] : pc_high_latch_r;
   assign low_fwd   = pc_nxt[PCS_LOW_W-1:0];

   // Read data registered at the address phase; unmapped reads return zero
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         hrdata_r <= '0;
      end else if (addr_ok && !hwrite) begin
         case (addr_sel)
            PCS_SEL_LOW:  hrdata_r <= {24'h000000, low_fwd};                           // [RULE2]
            PCS_SEL_HIGH: hrdata_r <= {27'h0000000, latch_fwd};                        // [RULE16]
            default:      hrdata_r <= '0;
         endcase
      end
   end

   // Push on call and on interrupt vectoring, pop on any return [RULE11] [RULE12]
   assign pop  = op.ret;
   assign push = !op.ret && (op.irq || op.call);
   assign push_data = op.irq ? pc_r : PCS_PC_W'(pc_r + 1'b1);

   // Sequencing priority: return, interrupt, call/goto, low-byte write, increment
   always_comb begin
      pc_nxt = pc_r;
      if (op.ret) begin
         pc_nxt = stack_top;                                                           // [RULE12]
      end else if (op.irq) begin
         pc_nxt = VECTOR;                                                              // [RULE11]
      end else if (op.call || op.jump) begin
         pc_nxt = {pc_high_latch_r[4:PCS_PAGE_LSB], op.target};                       // [RULE6] [RULE7]
      end else if (wr_low) begin
         pc_nxt = {pc_high_latch_r, hwdata[PCS_LOW_W-1:0]};                           // [RULE5] [RULE3]
      end else if (op.inc) begin
         pc_nxt = PCS_PC_W'(pc_r + 1'b1);                                             // [RULE1]
      end
   end

   // Every reset clears the counter [RULE4]
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pc_r <= PCS_PC_RST;
      end else begin
         pc_r <= pc_nxt;
      end
   end

   pcs_stack #(
      .DEPTH (DEPTH),
      .WIDTH (PCS_PC_W)
   ) u_stack (
      .clk       (clk),
      .rst_n     (rst_n),
      .push      (push),
      .pop       (pop),
      .push_data (push_data),
      .top       (stack_top)
   );                                                                                 // [RULE9] [RULE10]

   logic quiet_op;
   assign quiet_op = !(op.ret || op.irq || op.call || op.jump);

   property p_low_write;
      @(posedge clk) disable iff (!rst_n)
      (wr_low && quiet_op) |=> (pc_r == {$past(pc_high_latch_r), $past(hwdata[7:0])});
   endproperty
   a_low_write: assert property (p_low_write) else $error("low byte write load wrong"); // [RULE5]

   property p_call_page;
      @(posedge clk) disable iff (!rst_n)
      (!op.ret && !op.irq && (op.call || op.jump)) |=>
         (pc_r[12:11] == $past(pc_high_latch_r[4:3]) && pc_r[10:0] == $past(op.target));
   endproperty
   a_call_page: assert property (p_call_page) else $error("call or goto target wrong"); // [RULE6]

   property p_call_return;
      @(posedge clk) disable iff (!rst_n)
      (op.call && quiet_op == 1'b0 && !op.ret && !op.irq) ##1 op.ret |=>
         (pc_r == PCS_PC_W'($past(pc_r, 2) + 1'b1));
   endproperty
   a_call_return: assert property (p_call_return) else $error("return did not restore address"); // [RULE12]

   property p_irq_vector;
      @(posedge clk) disable iff (!rst_n)
      (op.irq && !op.ret) |=> (pc_r == VECTOR);
   endproperty
   a_irq_vector: assert property (p_irq_vector) else $error("interrupt did not vector"); // [RULE11]

   property p_latch_kept;
      @(posedge clk) disable iff (!rst_n)
      ((push || pop) && !wr_high) |=> $stable(pc_high_latch_r);
   endproperty
   a_latch_kept: assert property (p_latch_kept) else $error("stack action changed latch"); // [RULE13]

   property p_latch_read;
      @(posedge clk) disable iff (!rst_n)
      (addr_ok && !hwrite && addr_sel == PCS_SEL_HIGH) |=> (hrdata[31:PCS_HIGH_W] == '0);
   endproperty
   a_latch_read: assert property (p_latch_read) else $error("latch top bits not zero"); // [RULE16]

   property p_inc;
      @(posedge clk) disable iff (!rst_n)
      (op.inc && quiet_op && !wr_low) |=> (pc_r == PCS_PC_W'($past(pc_r) + 1'b1));
   endproperty
   a_inc: assert property (p_inc) else $error("counter did not advance"); // [RULE1]

   // Stack side effects of each request
   property p_ret_pop;
      @(posedge clk) disable iff (!rst_n)
      op.ret |=>
         (pc_r == $past(stack_top));
   endproperty
   a_ret_pop: assert property (p_ret_pop) else $error("return did not load stack top"); // [RULE12]

   property p_irq_push;
      @(posedge clk) disable iff (!rst_n)
      (op.irq && !op.ret) |=>
         (stack_top == $past(pc_r));
   endproperty
   a_irq_push: assert property (p_irq_push) else $error("interrupt did not save counter"); // [RULE11]

   property p_call_push;
      @(posedge clk) disable iff (!rst_n)
      (op.call && !op.ret && !op.irq) |=>
         (stack_top == PCS_PC_W'($past(pc_r) + 1'b1));
   endproperty
   a_call_push: assert property (p_call_push) else $error("call did not save return address"); // [RULE11]

   property p_jump_no_push;
      @(posedge clk) disable iff (!rst_n)
      (op.jump && !op.call && !op.ret && !op.irq) |=>
         (stack_top == $past(stack_top));
   endproperty
   a_jump_no_push: assert property (p_jump_no_push) else $error("goto touched the stack"); // [RULE11]

   property p_latch_sw_only;
      @(posedge clk) disable iff (!rst_n)
      !wr_high |=>
         $stable(pc_high_latch_r);
   endproperty
   a_latch_sw_only: assert property (p_latch_sw_only) else $error("latch changed without a write"); // [RULE13]

   // Register reads and the latch
   property p_latch_write;
      @(posedge clk) disable iff (!rst_n)
      wr_high |=>
         (pc_high_latch_r == $past(hwdata[PCS_HIGH_W-1:0]));
   endproperty
   a_latch_write: assert property (p_latch_write) else $error("latch write not stored"); // [RULE16]

   property p_latch_value;
      @(posedge clk) disable iff (!rst_n)
      (addr_ok && !hwrite && addr_sel == PCS_SEL_HIGH) |=>
         (hrdata[PCS_HIGH_W-1:0] == pc_high_latch_r);
   endproperty
   a_latch_value: assert property (p_latch_value) else $error("latch read value wrong"); // [RULE16]

   property p_low_read;
      @(posedge clk) disable iff (!rst_n)
      (addr_ok && !hwrite && addr_sel == PCS_SEL_LOW) |=>
         (hrdata == {24'h000000, pc_r[PCS_LOW_W-1:0]});
   endproperty
   a_low_read: assert property (p_low_read) else $error("low byte read wrong"); // [RULE2]

   property p_unmapped_read;
      @(posedge clk) disable iff (!rst_n)
      (addr_ok && !hwrite && addr_sel == PCS_SEL_NONE) |=>
         (hrdata == 32'h00000000);
   endproperty
   a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero"); // [RULE10]

   // Values held while reset is low
   property p_reset_pc;
      @(posedge clk)
      !rst_n |=>
         (pc_r == PCS_PC_RST);
   endproperty
   a_reset_pc: assert property (p_reset_pc) else $error("reset did not clear counter"); // [RULE4]

   property p_reset_latch;
      @(posedge clk)
      !rst_n |=>
         (pc_high_latch_r == PCS_PC_HIGH_RST);
   endproperty
   a_reset_latch: assert property (p_reset_latch) else $error("reset did not clear latch"); // [RULE16]

   property p_reset_rdata;
      @(posedge clk)
      !rst_n |=>
         (hrdata == 32'h00000000);
   endproperty
   a_reset_rdata: assert property (p_reset_rdata) else $error("reset did not clear read data"); // [RULE4]

   // Counter behaviour between requests
   property p_pc_hold;
      @(posedge clk) disable iff (!rst_n)
      (!op.inc && quiet_op && !wr_low) |=>
         $stable(pc_r);
   endproperty
   a_pc_hold: assert property (p_pc_hold) else $error("counter moved without a request"); // [RULE3]

   property p_inc_run;
      @(posedge clk) disable iff (!rst_n)
      (op.inc && quiet_op && !wr_low) [*8] |=>
         (pc_r == PCS_PC_W'($past(pc_r, 8) + 4'h8));
   endproperty
   a_inc_run: assert property (p_inc_run) else $error("counter run lost a step"); // [RULE1]

   c_low_write: cover property (@(posedge clk) disable iff (!rst_n) wr_low && quiet_op);
   c_call_ret:  cover property (@(posedge clk) disable iff (!rst_n) op.call ##1 op.ret);
   c_irq:       cover property (@(posedge clk) disable iff (!rst_n) op.irq);
   c_inc:       cover property (@(posedge clk) disable iff (!rst_n) op.inc ##1 op.inc);

endmodule // pcs_core

/* test/pcs_dec_model.sv */
`timescale 1ns/100ps
module pcs_dec_model
   import pcs_pkg::*;
(
   input  wire logic clk,
   output pcs_op_t   op
);
   initial op = '0;

   // Kind is {call, jump, ret, irq}; one pulse, then an idle cycle
   // Targets stay inside the current page, as no carry reaches the high part
   task automatic issue(input logic [3:0] kind, input logic [PCS_TARGET_W-1:0] tgt);
      @(posedge clk);
      op <= {1'b0, kind, tgt};
      @(posedge clk);
      op <= '0;
   endtask

   // Holds the increment request for n cycles
   task automatic advance(input int n);
      @(posedge clk);
      op.inc <= 1'b1;
      repeat (n) @(posedge clk);
      op.inc <= 1'b0;
   endtask

   // Call followed at once by a return
   task automatic call_ret(input logic [PCS_TARGET_W-1:0] tgt);
      @(posedge clk);
      op <= {1'b0, 4'h8, tgt};
      @(posedge clk);
      op <= {1'b0, 4'h2, tgt};
      @(posedge clk);
      op <= '0;
   endtask
endmodule // pcs_dec_model

/* test/tb_top.sv */
`timescale 1ns/100ps
module tb_top;
   import pcs_pkg::*;
   logic                clk;
   logic                rst_n;
   logic                hsel;
   logic [31:0]         haddr;
   logic [1:0]          htrans;
   logic                hwrite;
   logic [2:0]          hsize;
   logic                hready;
   logic [31:0]         hwdata;
   logic [31:0]         hrdata;
   logic                hreadyout;
   logic                hresp;
   pcs_op_t             op;
   logic [PCS_PC_W-1:0] pc;
   logic [31:0]         rd;
   int                  n_mismatch = 0;
   int                  checks_done = 0;
   int                  cyc = 0;

   assign hready = hreadyout;

   pcs_core u_dut (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .op(op), .pc(pc));
   pcs_dec_model u_dec (.clk(clk), .op(op));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         n_mismatch++;
         print_verdict();
      end
   end

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask

   // Single word transfer; read data taken at the edge closing the data phase
   task automatic bus(input logic wr, input logic [13:0] a, input logic [31:0] wd, output logic [31:0] rdat);
      @(posedge clk);
      htrans <= PCS_HTRANS_NONSEQ;
      haddr  <= {18'h0, a};
      hwrite <= wr;
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      htrans <= PCS_HTRANS_IDLE;
      hwdata <= wd;
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      rdat = hrdata;
      chk("hresp", 32'h0, {31'h0, hresp});
      #1;
   endtask

   task automatic t_reset;
      bus(1'b0, PCS_ADDR_PC_LOW, 32'h0, rd);
      chk("pc_low", 32'h0, rd);
      bus(1'b0, PCS_ADDR_PC_HIGH, 32'h0, rd);
      chk("pc_high", 32'h0, rd);
      chk("pc", 32'h0, {19'h0, pc});
      $display("test reset done");
   endtask

   task automatic t_write;
      bus(1'b1, PCS_ADDR_PC_HIGH, 32'hFF, rd);
      bus(1'b0, PCS_ADDR_PC_HIGH, 32'h0, rd);
      chk("pc_high", 32'h1F, rd);
      bus(1'b1, PCS_ADDR_PC_LOW, 32'h134, rd);
      chk("pc", 32'h1F34, {19'h0, pc});
      bus(1'b0, PCS_ADDR_PC_LOW, 32'h0, rd);
      chk("pc_low", 32'h34, rd);
      bus(1'b0, 14'h0100, 32'h0, rd);
      chk("unmapped", 32'h0, rd);
      $display("test write done");
   endtask

   task automatic t_call;
      u_dec.issue(4'h8, 11'h123);
      #1;
      chk("pc", 32'h1923, {19'h0, pc});
      u_dec.issue(4'h4, 11'h055);
      #1;
      chk("pc", 32'h1855, {19'h0, pc});
      u_dec.issue(4'h2, 11'h0);
      #1;
      chk("pc", 32'h1F35, {19'h0, pc});
      u_dec.issue(4'h1, 11'h0);
      #1;
      chk("pc", {19'h0, PCS_VECTOR_DEF}, {19'h0, pc});
      u_dec.issue(4'h2, 11'h0);
      #1;
      chk("pc", 32'h1F35, {19'h0, pc});
      bus(1'b0, PCS_ADDR_PC_HIGH, 32'h0, rd);
      chk("pc_high", 32'h1F, rd);
      $display("test call done");
   endtask

   // Ten pushes into eight slots: pops give pushes ten down to three, then wrap
   task automatic t_wrap;
      bus(1'b1, PCS_ADDR_PC_HIGH, 32'h0, rd);
      for (int k = 1; k <= 10; k++) u_dec.issue(4'h8, 11'(k * 16));
      for (int j = 1; j <= 9; j++) begin
         u_dec.issue(4'h2, 11'h0);
         #1;
         chk("pc", 32'(((10 - (j == 9 ? 1 : j)) * 16) + 1), {19'h0, pc});
      end
      $display("test wrap done");
   endtask

   // Increment across a byte boundary, call then return at once, request priority
   task automatic t_seq;
      bus(1'b1, PCS_ADDR_PC_HIGH, 32'h2, rd);
      bus(1'b1, PCS_ADDR_PC_LOW, 32'hFE, rd);
      chk("pc", 32'h2FE, {19'h0, pc});
      u_dec.advance(10);
      #1;
      chk("pc", 32'h308, {19'h0, pc});
      bus(1'b0, PCS_ADDR_PC_LOW, 32'h0, rd);
      chk("pc_low", 32'h8, rd);
      bus(1'b0, PCS_ADDR_PC_HIGH, 32'h0, rd);
      chk("pc_high", 32'h2, rd);
      u_dec.call_ret(11'h7AB);
      #1;
      chk("pc", 32'h309, {19'h0, pc});
      u_dec.issue(4'h9, 11'h444);
      #1;
      chk("pc", {19'h0, PCS_VECTOR_DEF}, {19'h0, pc});
      u_dec.issue(4'hA, 11'h444);
      #1;
      chk("pc", 32'h309, {19'h0, pc});
      $display("test sequence done");
   endtask

   // Reset in mid-run clears the counter and the latch
   task automatic t_rst2;
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      #1;
      chk("pc", 32'h0, {19'h0, pc});
      bus(1'b0, PCS_ADDR_PC_HIGH, 32'h0, rd);
      chk("pc_high", 32'h0, rd);
      $display("test mid-run reset done");
   endtask

   initial begin
      rst_n  = 1'b0;
      hsel   = 1'b1;
      haddr  = 32'h0;
      htrans = PCS_HTRANS_IDLE;
      hwrite = 1'b0;
      hsize  = 3'h2;
      hwdata = 32'h0;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_write();
      t_call();
      t_wrap();
      t_seq();
      t_rst2();
      print_verdict();
   end
endmodule // tb_top
